// [verilog/gpde_ports.sv]
// Port D and port E general-purpose I/O with peripheral pin sharing, AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module gpde_ports #(
   parameter int PD_WIDTH = 8,
   parameter int PE_WIDTH = 6
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port D pins
   input wire logic [PD_WIDTH-1:0] pd_in,
   output logic [PD_WIDTH-1:0] pd_out,
   output logic [PD_WIDTH-1:0] pd_oe,
   output logic [PD_WIDTH-1:0] pd_pullup,
   // Port E pins
   input wire logic [PE_WIDTH-1:0] pe_in,
   output logic [PE_WIDTH-1:0] pe_out,
   output logic [PE_WIDTH-1:0] pe_oe,
   // SPI peripheral side
   input wire logic spi_sck_out,
   input wire logic spi_sck_oe,
   input wire logic spi_mosi_out,
   input wire logic spi_mosi_oe,
   input wire logic spi_miso_out,
   input wire logic spi_miso_oe,
   output logic spi_sck_in,
   output logic spi_mosi_in,
   output logic spi_miso_in,
   output logic spi_ss_in_n,
   // Timer channel side
   input wire logic [1:0] tmr_ch_out,
   input wire logic [1:0] tmr_ch_oe,
   output logic [1:0] tmr_ch_in,
   // Serial interface side
   input wire logic ser_txd,
   output logic ser_rxd,
   // Peripheral enables as seen by the pin muxes
   output logic spi_enable_bit,
   output logic spi_master_role_bit,
   output logic serial_iface_enable_bit
);

   // Register state
   logic [PD_WIDTH-1:0] pd_latch_q, pd_latch_d;
   logic [PE_WIDTH-1:0] pe_latch_q, pe_latch_d;
   logic [PD_WIDTH-1:0] pd_dir_q, pd_dir_d;
   logic [PD_WIDTH-1:0] pd_pue_q, pd_pue_d;
   logic [PE_WIDTH-1:0] pe_dir_q, pe_dir_d;
   logic [6:0] ctrl_q, ctrl_d;
   // Bus state
   logic aw_full_q, aw_full_d;
   logic w_full_q, w_full_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic do_write;
   logic [PD_WIDTH-1:0] pd_owned;
   logic [PE_WIDTH-1:0] pe_owned;
   logic [PD_WIDTH-1:0] pd_per_out, pd_per_oe;
   logic [PE_WIDTH-1:0] pe_per_out, pe_per_oe;
   logic [PD_WIDTH-1:0] pd_rd;
   logic [PE_WIDTH-1:0] pe_rd;
   logic ch0_on, ch1_on, ss_on;

   // Peripheral ownership of shared pins
   always_comb begin
      ch0_on = |ctrl_q[gpde_pkg::CTRL_CH0_ELS +: 2];
      ch1_on = |ctrl_q[gpde_pkg::CTRL_CH1_ELS +: 2];
      ss_on = ctrl_q[gpde_pkg::CTRL_SPI_EN] & ~ctrl_q[gpde_pkg::CTRL_SPI_MASTER];
      pd_owned = '0;
      pd_per_out = '0;
      pd_per_oe = '0;
      pd_owned[gpde_pkg::PD_CH0] = ch0_on;
      pd_owned[gpde_pkg::PD_CH1] = ch1_on;
      pd_owned[gpde_pkg::PD_SCK] = ctrl_q[gpde_pkg::CTRL_SPI_EN];
      pd_owned[gpde_pkg::PD_MOSI] = ctrl_q[gpde_pkg::CTRL_SPI_EN];
      pd_owned[gpde_pkg::PD_MISO] = ctrl_q[gpde_pkg::CTRL_SPI_EN];
      pd_owned[gpde_pkg::PD_SS] = ss_on;
      pd_per_out[gpde_pkg::PD_CH0] = tmr_ch_out[0];
      pd_per_oe[gpde_pkg::PD_CH0] = tmr_ch_oe[0];
      pd_per_out[gpde_pkg::PD_CH1] = tmr_ch_out[1];
      pd_per_oe[gpde_pkg::PD_CH1] = tmr_ch_oe[1];
      pd_per_out[gpde_pkg::PD_SCK] = spi_sck_out;
      pd_per_oe[gpde_pkg::PD_SCK] = spi_sck_oe;
      pd_per_out[gpde_pkg::PD_MOSI] = spi_mosi_out;
      pd_per_oe[gpde_pkg::PD_MOSI] = spi_mosi_oe;
      pd_per_out[gpde_pkg::PD_MISO] = spi_miso_out;
      pd_per_oe[gpde_pkg::PD_MISO] = spi_miso_oe;
      pe_owned = '0;
      pe_per_out = '0;
      pe_per_oe = '0;
      pe_owned[gpde_pkg::PE_TXD] = ctrl_q[gpde_pkg::CTRL_SERIAL_EN];
      pe_owned[gpde_pkg::PE_RXD] = ctrl_q[gpde_pkg::CTRL_SERIAL_EN];
      pe_per_out[gpde_pkg::PE_TXD] = ser_txd;
      pe_per_oe[gpde_pkg::PE_TXD] = 1'b1; // Transmit line always driven while the serial interface owns it
   end

   // Pin drivers; owned pins ignore direction, so in the SPI slave role the slave-select pin stays input
   genvar gi;
   generate
      for (gi = 0; gi < PD_WIDTH; gi++) begin : g_pd
         assign pd_oe[gi] = pd_owned[gi] ? pd_per_oe[gi] : pd_dir_q[gi];
         assign pd_out[gi] = pd_owned[gi] ? pd_per_out[gi] : pd_latch_q[gi];
         assign pd_pullup[gi] = pd_pue_q[gi] & ~pd_oe[gi];
         assign pd_rd[gi] = pd_dir_q[gi] ? pd_latch_q[gi] : pd_in[gi];
      end
      for (gi = 0; gi < PE_WIDTH; gi++) begin : g_pe
         assign pe_oe[gi] = pe_owned[gi] ? pe_per_oe[gi] : pe_dir_q[gi];
         assign pe_out[gi] = pe_owned[gi] ? pe_per_out[gi] : pe_latch_q[gi];
         assign pe_rd[gi] = pe_dir_q[gi] ? pe_latch_q[gi] : pe_in[gi];
      end
   endgenerate

   // Peripheral inputs; an idle slave select reads as deselected
   assign spi_sck_in = pd_in[gpde_pkg::PD_SCK];
   assign spi_mosi_in = pd_in[gpde_pkg::PD_MOSI];
   assign spi_miso_in = pd_in[gpde_pkg::PD_MISO];
   assign spi_ss_in_n = ss_on ? pd_in[gpde_pkg::PD_SS] : 1'b1;
   assign tmr_ch_in = {pd_in[gpde_pkg::PD_CH1], pd_in[gpde_pkg::PD_CH0]};
   assign ser_rxd = pe_in[gpde_pkg::PE_RXD];
   assign spi_enable_bit = ctrl_q[gpde_pkg::CTRL_SPI_EN];
   assign spi_master_role_bit = ctrl_q[gpde_pkg::CTRL_SPI_MASTER];
   assign serial_iface_enable_bit = ctrl_q[gpde_pkg::CTRL_SERIAL_EN];

   // Bus handshakes; each channel is held off while its slot is full
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready = ~w_full_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign do_write = aw_full_q & w_full_q & ~bvalid_q;

   // Next state for bus and registers
   always_comb begin
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      pd_latch_d = pd_latch_q;
      pe_latch_d = pe_latch_q;
      pd_dir_d = pd_dir_q;
      pd_pue_d = pd_pue_q;
      pe_dir_d = pe_dir_q;
      ctrl_d = ctrl_q;
      if (s_axi_awvalid && !aw_full_q) begin
         aw_full_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
         w_full_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      // Only byte lane 0 carries register data
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = gpde_pkg::RESP_OKAY;
         case ({awaddr_q[7:2], 2'b00})
            gpde_pkg::ADDR_PORT_D_DATA: begin
               if (wstrb_q[0]) pd_latch_d = wdata_q[PD_WIDTH-1:0];
            end
            gpde_pkg::ADDR_PORT_E_DATA: begin
               if (wstrb_q[0]) pe_latch_d = wdata_q[PE_WIDTH-1:0];
            end
            gpde_pkg::ADDR_PORT_D_DIR: begin
               if (wstrb_q[0]) pd_dir_d = wdata_q[PD_WIDTH-1:0];
            end
            gpde_pkg::ADDR_PORT_D_PULLUP: begin
               if (wstrb_q[0]) pd_pue_d = wdata_q[PD_WIDTH-1:0];
            end
            gpde_pkg::ADDR_PORT_E_DIR: begin
               if (wstrb_q[0]) pe_dir_d = wdata_q[PE_WIDTH-1:0];
            end
            gpde_pkg::ADDR_PERIPH_CTRL: begin
               if (wstrb_q[0]) ctrl_d = wdata_q[6:0];
            end
            default: bresp_d = gpde_pkg::RESP_SLVERR;
         endcase
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d = gpde_pkg::RESP_OKAY;
         rdata_d = 32'h0000_0000;
         case ({s_axi_araddr[7:2], 2'b00})
            gpde_pkg::ADDR_PORT_D_DATA: rdata_d[PD_WIDTH-1:0] = pd_rd;
            gpde_pkg::ADDR_PORT_E_DATA: rdata_d[PE_WIDTH-1:0] = pe_rd;
            gpde_pkg::ADDR_PORT_D_DIR: rdata_d[PD_WIDTH-1:0] = pd_dir_q;
            gpde_pkg::ADDR_PORT_D_PULLUP: rdata_d[PD_WIDTH-1:0] = pd_pue_q;
            gpde_pkg::ADDR_PORT_E_DIR: rdata_d[PE_WIDTH-1:0] = pe_dir_q;
            gpde_pkg::ADDR_PERIPH_CTRL: rdata_d[6:0] = ctrl_q;
            default: rresp_d = gpde_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Data latches carry no reset so their contents survive it
   always_ff @(posedge mclk) begin
      pd_latch_q <= pd_latch_d;
      pe_latch_q <= pe_latch_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      rdata_q <= rdata_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
   end

   // Control registers with synchronous reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         pd_dir_q <= gpde_pkg::PORT_D_DIR_RST[PD_WIDTH-1:0];
         pe_dir_q <= gpde_pkg::PORT_E_DIR_RST[PE_WIDTH-1:0];
         pd_pue_q <= gpde_pkg::PULLUP_RST[PD_WIDTH-1:0];
         ctrl_q <= gpde_pkg::CTRL_RST;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
      end else begin
         pd_dir_q <= pd_dir_d;
         pe_dir_q <= pe_dir_d;
         pd_pue_q <= pd_pue_d;
         ctrl_q <= ctrl_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         bvalid_q <= bvalid_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Checks on pin behaviour, latch retention and register access
   a_pd_reset_dir: assert property (@(posedge mclk) rst |=> pd_dir_q == '0)
      else $error("port D direction not cleared by reset");
   a_pe_reset_dir: assert property (@(posedge mclk) rst |=> pe_dir_q == '0)
      else $error("port E direction not cleared by reset");
   a_pullup_out_off: assert property (@(posedge mclk) disable iff (rst)
      (pd_oe & pd_pullup) == '0)
      else $error("pullup active on driven pin");
   a_pullup_input_on: assert property (@(posedge mclk) disable iff (rst)
      (pd_pue_q & ~pd_oe) == pd_pullup)
      else $error("pullup missing on input pin");
   a_gpio_dir_oe: assert property (@(posedge mclk) disable iff (rst)
      !ctrl_q[gpde_pkg::CTRL_SPI_EN] && ctrl_q[6:3] == 4'h0 |-> pd_oe == pd_dir_q)
      else $error("port D drive differs from direction");
   a_ss_master_gpio: assert property (@(posedge mclk) disable iff (rst)
      ctrl_q[gpde_pkg::CTRL_SPI_MASTER] |-> pd_oe[gpde_pkg::PD_SS] == pd_dir_q[gpde_pkg::PD_SS])
      else $error("slave select pin not released in master role");
   a_serial_txd: assert property (@(posedge mclk) disable iff (rst)
      ctrl_q[gpde_pkg::CTRL_SERIAL_EN] |-> pe_oe[gpde_pkg::PE_TXD] && !pe_oe[gpde_pkg::PE_RXD])
      else $error("serial pins not owned while enabled");
   a_latch_hold: assert property (@(posedge mclk)
      rst && !do_write |=> pd_latch_q === $past(pd_latch_q)
      && pe_latch_q === $past(pe_latch_q))
      else $error("data latch disturbed by reset");
   a_pd_read_sel: assert property (@(posedge mclk) disable iff (rst)
      s_axi_arvalid && !rvalid_q && s_axi_araddr == gpde_pkg::ADDR_PORT_D_DATA
      |=> rdata_q[PD_WIDTH-1:0] == $past(pd_rd))
      else $error("port D read returned wrong source");
   a_write_latch: assert property (@(posedge mclk) disable iff (rst)
      do_write && wstrb_q[0] && awaddr_q == gpde_pkg::ADDR_PORT_E_DATA
      |=> pe_latch_q == $past(wdata_q[PE_WIDTH-1:0]))
      else $error("port E latch write lost");

endmodule
`default_nettype wire

// [verilog/gpde_pkg.sv]
// Package with register map and layout constants for the port D/E pin block
package gpde_pkg;
   // Data registers keep their word index; the byte address is four times it
   localparam int IDX_PORT_D_DATA = 3;
   localparam int IDX_PORT_E_DATA = 8;
   // Byte addresses on the register bus
   localparam logic [7:0] ADDR_PORT_D_DATA = 8'(IDX_PORT_D_DATA * 4);
   localparam logic [7:0] ADDR_PORT_E_DATA = 8'(IDX_PORT_E_DATA * 4);
   localparam logic [7:0] ADDR_PORT_D_DIR = 8'h10;
   localparam logic [7:0] ADDR_PORT_D_PULLUP = 8'h14;
   localparam logic [7:0] ADDR_PORT_E_DIR = 8'h18;
   localparam logic [7:0] ADDR_PERIPH_CTRL = 8'h1c;
   // Peripheral control register fields
   localparam int CTRL_SPI_EN = 0;
   localparam int CTRL_SPI_MASTER = 1;
   localparam int CTRL_SERIAL_EN = 2;
   localparam int CTRL_CH0_ELS = 3;
   localparam int CTRL_CH1_ELS = 5;
   localparam int CTRL_WIDTH = 7;
   // Pin positions of shared functions
   localparam int PD_SS = 0;
   localparam int PD_MISO = 1;
   localparam int PD_MOSI = 2;
   localparam int PD_SCK = 3;
   localparam int PD_CH0 = 6;
   localparam int PD_CH1 = 7;
   localparam int PE_TXD = 0;
   localparam int PE_RXD = 1;
   // Reset values
   localparam logic [7:0] PORT_D_DIR_RST = 8'h00;
   localparam logic [5:0] PORT_E_DIR_RST = 6'h00;
   localparam logic [7:0] PULLUP_RST = 8'h00;
   localparam logic [6:0] CTRL_RST = 7'h00;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [tb/gpde_board.sv]
// Board model: resolves port pin levels from chip drive, external drive and pullups
`timescale 1ns/1ps
`default_nettype none
module gpde_board (
   // Clock
   input wire logic mclk,
   // Chip side
   input wire logic [7:0] pd_out,
   input wire logic [7:0] pd_oe,
   input wire logic [7:0] pd_pullup,
   input wire logic [5:0] pe_out,
   input wire logic [5:0] pe_oe,
   // External drivers on the board
   input wire logic [7:0] ext_d_val,
   input wire logic [7:0] ext_d_en,
   input wire logic [5:0] ext_e_val,
   input wire logic [5:0] ext_e_en,
   // Resolved pin levels
   output logic [7:0] pd_in,
   output logic [5:0] pe_in
);
   logic [7:0] d_last_q = 8'h00;
   logic [5:0] e_last_q = 6'h00;
   // Floating pins flip each cycle, so a stale level never passes for a real one
   always_comb begin
      pd_in = (pd_oe & pd_out) | (~pd_oe & ext_d_en & ext_d_val)
            | (~pd_oe & ~ext_d_en & (pd_pullup | ~d_last_q));
      pe_in = (pe_oe & pe_out) | (~pe_oe & ext_e_en & ext_e_val)
            | (~pe_oe & ~ext_e_en & ~e_last_q);
   end
   // Last level seen on each line
   always_ff @(posedge mclk) begin
      d_last_q <= pd_in;
      e_last_q <= pe_in;
   end
endmodule
`default_nettype wire

// [tb/test_gpio_ports_d_e_pin_sharing.sv]
// Testbench for the port D/E pin block over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module test_gpio_ports_d_e_pin_sharing;
   logic mclk = 1'b0, rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, tmr_ch_out = 2'h0, tmr_ch_oe = 2'h0, tmr_ch_in;
   logic [7:0] pd_in, pd_out, pd_oe, pd_pullup, ext_d_val = 8'h00, ext_d_en = 8'h00;
   logic [5:0] pe_in, pe_out, pe_oe, ext_e_val = 6'h00, ext_e_en = 6'h00;
   logic spi_sck_out = 1'b0, spi_sck_oe = 1'b0, spi_mosi_out = 1'b0, spi_mosi_oe = 1'b0;
   logic spi_miso_out = 1'b0, spi_miso_oe = 1'b0, ser_txd = 1'b0;
   logic spi_sck_in, spi_mosi_in, spi_miso_in, spi_ss_in_n, ser_rxd;
   logic spi_enable_bit, spi_master_role_bit, serial_iface_enable_bit;
   logic [31:0] rd;
   logic [1:0] rsp;
   int miscompares = 0, compares = 0;
   // Response channels always ready; the bus tasks still wait on valid
   gpde_ports u_gpde_ports (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .pd_in, .pd_out,
      .pd_oe, .pd_pullup, .pe_in, .pe_out, .pe_oe, .spi_sck_out, .spi_sck_oe, .spi_mosi_out,
      .spi_mosi_oe, .spi_miso_out, .spi_miso_oe, .spi_sck_in, .spi_mosi_in, .spi_miso_in,
      .spi_ss_in_n, .tmr_ch_out, .tmr_ch_oe, .tmr_ch_in, .ser_txd, .ser_rxd,
      .spi_enable_bit, .spi_master_role_bit, .serial_iface_enable_bit);
   gpde_board u_gpde_board (.mclk, .pd_out, .pd_oe, .pd_pullup, .pe_out, .pe_oe,
      .ext_d_val, .ext_d_en, .ext_e_val, .ext_e_en, .pd_in, .pe_in);
   // 125 MHz clock
   always #4 mclk = ~mclk;
   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: response %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      chk_resp(s_axi_bresp, er);
   endtask
   task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rdw(a, rd, rsp);
      chk_resp(rsp, gpde_pkg::RESP_OKAY);
      chk(rd, exp);
   endtask
   // Reset for 20 cycles, then every direction and pullup must read as cleared
   task automatic do_reset();
      rst <= 1'b1;
      ticks(20);
      rst <= 1'b0;
      @(posedge mclk);
      rchk(gpde_pkg::ADDR_PORT_D_DIR, 32'h0);
      rchk(gpde_pkg::ADDR_PORT_E_DIR, 32'h0);
      rchk(gpde_pkg::ADDR_PORT_D_PULLUP, 32'h0);
      chk({pd_oe, pe_oe, pd_pullup}, 32'h0);
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      ticks(20000);
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      stop_test();
   end
   initial begin
      do_reset();
      $display("test reset done");
      // Latch loaded before enabling outputs
      ext_d_en <= 8'hf0;
      ext_d_val <= 8'ha0;
      wr(gpde_pkg::ADDR_PORT_D_DATA, 32'h5c, gpde_pkg::RESP_OKAY);
      wr(gpde_pkg::ADDR_PORT_D_DIR, 32'h0f, gpde_pkg::RESP_OKAY);
      ticks(4);
      chk({pd_oe, pd_out[3:0]}, 32'h0fc);
      rchk(gpde_pkg::ADDR_PORT_D_DATA, 32'hac);
      wr(gpde_pkg::ADDR_PORT_D_DATA, 32'h33, gpde_pkg::RESP_OKAY);
      rchk(gpde_pkg::ADDR_PORT_D_DATA, 32'ha3);
      ext_d_en <= 8'h00;
      wr(gpde_pkg::ADDR_PORT_D_PULLUP, 32'hff, gpde_pkg::RESP_OKAY);
      rchk(gpde_pkg::ADDR_PORT_D_PULLUP, 32'hff);
      ticks(4);
      chk(pd_pullup, 32'hf0);
      rchk(gpde_pkg::ADDR_PORT_D_DATA, 32'hf3);
      wr(gpde_pkg::ADDR_PORT_D_DIR, 32'hff, gpde_pkg::RESP_OKAY);
      rchk(gpde_pkg::ADDR_PORT_D_DATA, 32'h33);
      $display("test port d done");
      // Port E mixed directions, then latches across a reset
      ext_e_en <= 6'h38;
      ext_e_val <= 6'h28;
      wr(gpde_pkg::ADDR_PORT_E_DATA, 32'h15, gpde_pkg::RESP_OKAY);
      wr(gpde_pkg::ADDR_PORT_E_DIR, 32'h07, gpde_pkg::RESP_OKAY);
      ticks(4);
      chk({pe_oe, pe_out[2:0]}, 32'h3d);
      rchk(gpde_pkg::ADDR_PORT_E_DATA, 32'h2d);
      wr(gpde_pkg::ADDR_PORT_D_DATA, 32'h96, gpde_pkg::RESP_OKAY);
      do_reset();
      wr(gpde_pkg::ADDR_PORT_D_DIR, 32'hff, gpde_pkg::RESP_OKAY);
      wr(gpde_pkg::ADDR_PORT_E_DIR, 32'h3f, gpde_pkg::RESP_OKAY);
      rchk(gpde_pkg::ADDR_PORT_D_DATA, 32'h96);
      rchk(gpde_pkg::ADDR_PORT_E_DATA, 32'h15);
      $display("test latches done");
      // SPI slave role owns pins 3..0 whatever the direction says
      wr(gpde_pkg::ADDR_PORT_D_DIR, 32'h0e, gpde_pkg::RESP_OKAY);
      spi_sck_oe <= 1'b1;
      spi_sck_out <= 1'b1;
      spi_miso_oe <= 1'b1;
      ext_d_en <= 8'hf5;
      ext_d_val <= 8'h94;
      wr(gpde_pkg::ADDR_PERIPH_CTRL, 32'h01, gpde_pkg::RESP_OKAY);
      ticks(4);
      chk({pd_oe[3:0], pd_out[3], pd_out[1]}, 32'h2a);
      chk({spi_ss_in_n, spi_mosi_in, spi_sck_in}, 32'h3);
      rchk(gpde_pkg::ADDR_PORT_D_DATA, 32'h96);
      wr(gpde_pkg::ADDR_PERIPH_CTRL, 32'h03, gpde_pkg::RESP_OKAY);
      ticks(4);
      chk(spi_ss_in_n, 32'h1);
      wr(gpde_pkg::ADDR_PERIPH_CTRL, 32'h00, gpde_pkg::RESP_OKAY);
      chk(pd_oe[3:0], 32'he);
      $display("test spi done");
      // Every select value of both timer channels, pins set as inputs
      wr(gpde_pkg::ADDR_PORT_D_DIR, 32'h00, gpde_pkg::RESP_OKAY);
      tmr_ch_oe <= 2'b11;
      tmr_ch_out <= 2'b01;
      for (int ch = 0; ch < 2; ch++) begin
         for (int els = 0; els < 4; els++) begin
            wr(gpde_pkg::ADDR_PERIPH_CTRL, 32'(els) << (3 + 2 * ch), gpde_pkg::RESP_OKAY);
            chk(pd_oe[6 + ch], 32'(els != 0));
            chk(pd_out[6 + ch], 32'((els != 0) ? (ch == 0) : (ch == 1)));
         end
      end
      $display("test timer done");
      // Serial interface takes port E pins 1 and 0
      wr(gpde_pkg::ADDR_PORT_E_DIR, 32'h02, gpde_pkg::RESP_OKAY);
      ser_txd <= 1'b1;
      ext_e_en <= 6'h02;
      ext_e_val <= 6'h00;
      wr(gpde_pkg::ADDR_PERIPH_CTRL, 32'h04, gpde_pkg::RESP_OKAY);
      ticks(4);
      chk({pe_oe[1:0], pe_out[0], ser_rxd}, 32'h6);
      wr(gpde_pkg::ADDR_PERIPH_CTRL, 32'h00, gpde_pkg::RESP_OKAY);
      chk(pe_oe[1:0], 32'h2);
      $display("test serial done");
      // Unmapped address is refused on both paths
      wr(8'h40, 32'hff, gpde_pkg::RESP_SLVERR);
      rdw(8'h40, rd, rsp);
      chk_resp(rsp, gpde_pkg::RESP_SLVERR);
      chk(rd, 32'h0);
      $display("test unmapped done");
      stop_test();
   end
endmodule
`default_nettype wire
